// [hw/ppp_pkg.sv]
// package of constants and types for the parallel programming port
`default_nettype none
package ppp_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int PULSE_MIN_NS = 250;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int ENTRY_HOLD_US = 10;
   localparam int ENTRY_HOLD_CYC = ENTRY_HOLD_US * CLK_MHZ;
   localparam int CMD_WAIT_US = 300;
   localparam int CMD_WAIT_CYC = CMD_WAIT_US * CLK_MHZ;
   localparam int BUSY_CYC_DEF = 64;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int FLASH_WORDS = 1024;
   localparam int FLASH_PAGE_WORDS = 16;
   localparam int FLASH_PAGES = 64;
   localparam int FLASH_WORD_LSB = 0;
   localparam int FLASH_WORD_MSB = 3;
   localparam int FLASH_PAGE_LSB = 4;
   localparam int FLASH_PAGE_MSB = 9;
   localparam int EE_BYTES = 128;
   localparam int EE_PAGE_BYTES = 4;
   localparam int EE_PAGES = 32;
   localparam int EE_BYTE_MSB = 1;
   localparam int EE_PAGE_LSB = 2;
   localparam int EE_PAGE_MSB = 6;
   // ----------------------------------------
   // action codes and commands
   // ----------------------------------------
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE = 8'h11;
   localparam logic [7:0] CMD_RD_SIG = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EE = 8'h03;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] FUSE_LO_RST = 8'h64;
   localparam logic [7:0] FUSE_HI_RST = 8'hdf;
   localparam logic [7:0] FUSE_EXT_RST = 8'hff;
   localparam logic [7:0] LOCK_RST = 8'hff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int KEEP_EE_BIT = 6;
   // arbitrary identity and calibration defaults
   localparam logic [7:0] SIG0_DEF = 8'h5a;
   localparam logic [7:0] SIG1_DEF = 8'h3c;
   localparam logic [7:0] SIG2_DEF = 8'h01;
   localparam logic [7:0] CAL8_DEF = 8'h80;
   localparam logic [7:0] CAL4_DEF = 8'h80;
   typedef enum {PPP_IDLE, PPP_ERASE, PPP_WRITE} ppp_state_t;
endpackage
`default_nettype wire

// [hw/ppp_mem_if.sv]
// memory access interface between the port core and its storage
`default_nettype none
interface ppp_mem_if #(parameter int AW = 10, parameter int DW = 16);
   logic wrEn;
   logic [AW-1:0] wrAddr;
   logic [DW-1:0] wrData;
   logic [AW-1:0] rdAddr;
   logic [DW-1:0] rdData;
   modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
   modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

// [hw/ppp_mem.sv]
// simple synchronous memory with registered read data
`default_nettype none
module ppp_mem #(
   parameter int AW = 10,
   parameter int DW = 16
) (
   // clock
   input wire logic clk,
   // access
   ppp_mem_if.mem port
);
   logic [DW-1:0] store [0:(1<<AW)-1];
   logic [DW-1:0] rdData_q;
   // write port, contents not reset
   always_ff @(posedge clk) begin
      if (port.wrEn) begin
         store[port.wrAddr] <= port.wrData;
      end
   end
   // registered read
   always_ff @(posedge clk) begin
      rdData_q <= store[port.rdAddr];
   end
   assign port.rdData = rdData_q;
endmodule // ppp_mem
`default_nettype wire

// [hw/ppp_port.sv]
// parallel nonvolatile programming port core
`default_nettype none
// Overview of operation
// - fuse values seen by the device latch on programming entry
// - keep-eeprom fuse acts as soon as it is programmed
// - fuses also latch at power-up in normal mode
// - three signature bytes at signature addresses 0 to 2, readable when locked
// - calibration bytes in high byte: 8 MHz at 0, 4 MHz at 1
// - every reset copies 8 MHz calibration into oscillator trim
// - flash is 64 pages of 16 words, word in bits 3:0
// - eeprom is 32 pages of 4 bytes, byte in bits 1:0
// - load strobe rising edge loads address, data or command by action code
// - write or read strobe runs the last loaded command
// - decode chip erase, write fuses and write lock commands
// - decode read signature and read fuse and lock commands
// - decode write and read of flash and eeprom
// - ready flag low while busy, high when ready
// - data bus driven only while output enable is low
// - low byte select picks low or high byte, also page load
// - upper action bit picks the extended byte
// - programming mode ends on power down or reset low
// - loaded command and address persist across accesses
module ppp_port
   import ppp_pkg::*;
#(
   parameter int BUSY_CYC = BUSY_CYC_DEF,
   parameter logic [7:0] SIG0 = SIG0_DEF,
   parameter logic [7:0] SIG1 = SIG1_DEF,
   parameter logic [7:0] SIG2 = SIG2_DEF,
   parameter logic [7:0] CAL8 = CAL8_DEF,
   parameter logic [7:0] CAL4 = CAL4_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // programming mode request, high voltage present on reset pin
   input wire logic hvReset,
   // programmer pins
   input wire logic load_strobe,
   input wire logic action_code_bit0,
   input wire logic action_code_bit1,
   input wire logic byte_select_lo,
   input wire logic writeStrobeN,
   input wire logic outEnableN,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe,
   output logic prog_ready_flag,
   // device side status
   output logic progMode,
   output logic [7:0] fuseLoActive,
   output logic [7:0] fuseHiActive,
   output logic [7:0] fuseExtActive,
   output logic keep_eeprom_on_erase,
   output logic [7:0] oscillator_trim_register,
   output logic [7:0] lockBits
);
   import ppp_pkg::*;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int NPIN = 7;
   logic [NPIN-1:0] pinRaw;
   logic [NPIN-1:0] pinS1_q;
   logic [NPIN-1:0] pinS2_q;
   logic [NPIN-1:0] pinS3_q;
   logic [7:0] datS1_q;
   logic [7:0] datS2_q;
   assign pinRaw = {hvReset, load_strobe, action_code_bit1, action_code_bit0,
                    byte_select_lo, writeStrobeN, outEnableN};
   // two stages, third kept only for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         pinS1_q <= 7'h03;
         pinS2_q <= 7'h03;
         pinS3_q <= 7'h03;
         datS1_q <= 8'h00;
         datS2_q <= 8'h00;
      end else begin
         pinS1_q <= pinRaw;
         pinS2_q <= pinS1_q;
         pinS3_q <= pinS2_q;
         datS1_q <= dataIn;
         datS2_q <= datS1_q;
      end
   end
   logic hvS, xtalRise, wrFall, oeS, bs1S, xa0S, xa1S, wrS;
   assign hvS = pinS2_q[6];
   assign xa1S = pinS2_q[4];
   assign xa0S = pinS2_q[3];
   assign bs1S = pinS2_q[2];
   assign wrS = pinS2_q[1];
   assign oeS = pinS2_q[0];
   assign xtalRise = pinS2_q[5] & ~pinS3_q[5];
   assign wrFall = ~pinS2_q[1] & pinS3_q[1];
   // ----------------------------------------
   // mode entry
   // ----------------------------------------
   logic mode_q, hvPrev_q;
   logic [7:0] fuseLo_q, fuseHi_q, fuseExt_q, lock_q;
   logic enter;
   // entry pattern sampled on the rising edge of high voltage
   assign enter = hvS & ~hvPrev_q & ~xa1S & ~xa0S & ~bs1S & ~wrS;
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= 1'b0;
         hvPrev_q <= 1'b0;
      end else begin
         hvPrev_q <= hvS;
         if (!hvS) begin
            mode_q <= 1'b0;
         end else if (enter) begin
            mode_q <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // latched fuses and trim
   // ----------------------------------------
   logic started_q;
   // latch on power-up, entry and exit
   always_ff @(posedge clk) begin
      if (rst) begin
         started_q <= 1'b0;
         fuseLoActive <= FUSE_LO_RST;
         fuseHiActive <= FUSE_HI_RST;
         fuseExtActive <= FUSE_EXT_RST;
      end else begin
         started_q <= 1'b1;
         if (!started_q || enter || (mode_q && !hvS)) begin
            fuseLoActive <= fuseLo_q;
            fuseHiActive <= fuseHi_q;
            fuseExtActive <= fuseExt_q;
         end
      end
   end
   // keep-eeprom follows the stored fuse at once
   always_ff @(posedge clk) begin
      if (rst) begin
         keep_eeprom_on_erase <= 1'b0;
      end else begin
         keep_eeprom_on_erase <= ~fuseHi_q[KEEP_EE_BIT];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         oscillator_trim_register <= CAL8;
      end else begin
         oscillator_trim_register <= oscillator_trim_register;
      end
   end
   assign progMode = mode_q;
   // ----------------------------------------
   // command, address and data loading
   // ----------------------------------------
   logic [7:0] cmd_q, addrLo_q, addrHi_q, datLo_q, datHi_q;
   // load strobe actions, kept between accesses
   always_ff @(posedge clk) begin
      if (rst || !mode_q) begin
         cmd_q <= CMD_NOP;
         addrLo_q <= 8'h00;
         addrHi_q <= 8'h00;
         datLo_q <= 8'h00;
         datHi_q <= 8'h00;
      end else if (xtalRise) begin
         case ({xa1S, xa0S})
            ACT_ADDR: begin
               if (bs1S) addrHi_q <= datS2_q;
               else addrLo_q <= datS2_q;
            end
            ACT_DATA: begin
               if (bs1S) datHi_q <= datS2_q;
               else datLo_q <= datS2_q;
            end
            ACT_CMD: cmd_q <= datS2_q;
            default: ;
         endcase
      end
   end
   // ----------------------------------------
   // page buffers
   // ----------------------------------------
   logic [7:0] flashBufLo [0:FLASH_PAGE_WORDS-1];
   logic [7:0] flashBufHi [0:FLASH_PAGE_WORDS-1];
   logic [7:0] eeBuf [0:EE_PAGE_BYTES-1];
   logic [FLASH_WORD_MSB:0] wordIdx;
   logic [EE_BYTE_MSB:0] eeByteIdx;
   // word and byte within a page
   assign wordIdx = addrLo_q[FLASH_WORD_MSB:FLASH_WORD_LSB];
   assign eeByteIdx = addrLo_q[EE_BYTE_MSB:0];
   // data load fills the page buffer entry
   always_ff @(posedge clk) begin
      if (mode_q && xtalRise && {xa1S, xa0S} == ACT_DATA) begin
         if (bs1S) flashBufHi[wordIdx] <= datS2_q;
         else flashBufLo[wordIdx] <= datS2_q;
         if (!bs1S) eeBuf[eeByteIdx] <= datS2_q;
      end
   end
   // ----------------------------------------
   // operation sequencer
   // ----------------------------------------
   ppp_state_t state_q;
   logic [15:0] busyCnt_q;
   logic [9:0] sweep_q;
   logic eraseEe_q;
   ppp_mem_if #(.AW(10), .DW(16)) flashIf ();
   ppp_mem_if #(.AW(7), .DW(8)) eeIf ();
   logic locked, flashAddrOk;
   assign locked = (lock_q[0] == 1'b0);
   assign flashAddrOk = 1'b1;
   // write strobe starts the loaded command
   always_ff @(posedge clk) begin
      if (rst || !mode_q) begin
         state_q <= PPP_IDLE;
         busyCnt_q <= 16'h0000;
         sweep_q <= 10'h000;
         eraseEe_q <= 1'b0;
      end else begin
         case (state_q)
            PPP_IDLE: begin
               if (wrFall) begin
                  busyCnt_q <= 16'(BUSY_CYC);
                  sweep_q <= 10'h000;
                  eraseEe_q <= fuseHi_q[KEEP_EE_BIT]; // unprogrammed keep fuse wipes eeprom
                  if (cmd_q == CMD_CHIP_ERASE) state_q <= PPP_ERASE;
                  else if (cmd_q == CMD_WR_FLASH || cmd_q == CMD_WR_EE ||
                           cmd_q == CMD_WR_FUSE || cmd_q == CMD_WR_LOCK) begin
                     state_q <= PPP_WRITE;
                  end
               end
            end
            PPP_ERASE: begin
               sweep_q <= sweep_q + 10'h001;
               if (sweep_q == 10'h3ff) state_q <= PPP_WRITE;
            end
            PPP_WRITE: begin
               sweep_q <= (sweep_q == 10'h00f) ? sweep_q : sweep_q + 10'h001;
               busyCnt_q <= (busyCnt_q == 16'h0000) ? busyCnt_q : busyCnt_q - 16'h0001;
               if (busyCnt_q <= 16'h0001 && sweep_q == 10'h00f) state_q <= PPP_IDLE;
            end
            default: state_q <= PPP_IDLE;
         endcase
      end
   end
   // storage write steering, page write walks the buffer
   logic pageWr;
   logic [3:0] sweepLo;
   assign sweepLo = sweep_q[3:0];
   assign pageWr = (state_q == PPP_WRITE) && (sweep_q < 10'h010) && !locked;
   assign flashIf.wrEn = (state_q == PPP_ERASE) ||
                         (pageWr && cmd_q == CMD_WR_FLASH && sweep_q < 10'h010);
   assign flashIf.wrAddr = (state_q == PPP_ERASE) ? sweep_q :
                           {addrHi_q[1:0], addrLo_q[7:FLASH_PAGE_LSB], sweepLo};
   assign flashIf.wrData = (state_q == PPP_ERASE) ? {ERASED_BYTE, ERASED_BYTE} :
                           {flashBufHi[sweepLo], flashBufLo[sweepLo]};
   assign eeIf.wrEn = ((state_q == PPP_ERASE) && eraseEe_q && sweep_q < 10'h080) ||
                      (pageWr && cmd_q == CMD_WR_EE && sweep_q < 10'h004);
   assign eeIf.wrAddr = (state_q == PPP_ERASE) ? sweep_q[6:0] :
                        {addrLo_q[EE_PAGE_MSB:EE_PAGE_LSB], sweep_q[1:0]};
   assign eeIf.wrData = (state_q == PPP_ERASE) ? ERASED_BYTE : eeBuf[sweep_q[1:0]];
   assign flashIf.rdAddr = {addrHi_q[1:0], addrLo_q};
   assign eeIf.rdAddr = addrLo_q[6:0];
   ppp_mem #(.AW(10), .DW(16)) flashMem (.clk(clk), .port(flashIf.mem));
   ppp_mem #(.AW(7), .DW(8)) eeMem (.clk(clk), .port(eeIf.mem));
   // fuses and lock bits, held through a one-cycle reset of the port, reloaded from the second reset cycle on
   logic doWr;
   assign doWr = mode_q && (state_q == PPP_IDLE) && wrFall;
   always_ff @(posedge clk) begin
      if (rst && !started_q) begin
         fuseLo_q <= FUSE_LO_RST;
         fuseHi_q <= FUSE_HI_RST;
         fuseExt_q <= FUSE_EXT_RST;
         lock_q <= LOCK_RST;
      end else if (state_q == PPP_ERASE && sweep_q == 10'h3ff) begin
         lock_q <= LOCK_RST;
      end else if (mode_q && doWr && cmd_q == CMD_WR_LOCK) begin
         lock_q <= lock_q & datLo_q;
      end else if (mode_q && doWr && cmd_q == CMD_WR_FUSE && !locked) begin
         // second select picks the extended byte
         if (xa1S) fuseExt_q <= datLo_q;
         else if (bs1S) fuseHi_q <= datLo_q;
         else fuseLo_q <= datLo_q;
      end
   end
   assign lockBits = lock_q;
   // ----------------------------------------
   // read path and pins
   // ----------------------------------------
   // signature and calibration, not gated by lock
   function automatic logic [7:0] sigByte(input logic [1:0] a, input logic hi);
      if (hi) sigByte = (a == 2'h0) ? CAL8 : (a == 2'h1) ? CAL4 : 8'h00;
      else sigByte = (a == 2'h0) ? SIG0 : (a == 2'h1) ? SIG1 : (a == 2'h2) ? SIG2 : 8'h00;
   endfunction
   logic [7:0] rdByte;
   always_comb begin
      rdByte = 8'h00;
      case (cmd_q)
         CMD_RD_SIG: rdByte = sigByte(addrLo_q[1:0], bs1S);
         CMD_RD_FUSE: begin
            if (xa1S && bs1S) rdByte = fuseHi_q;
            else if (xa1S) rdByte = fuseExt_q;
            else if (bs1S) rdByte = lock_q;
            else rdByte = fuseLo_q;
         end
         CMD_RD_FLASH: begin
            if (lock_q[1:0] != 2'h0) rdByte = bs1S ? flashIf.rdData[15:8] : flashIf.rdData[7:0];
         end
         CMD_RD_EE: begin
            if (lock_q[1:0] != 2'h0) rdByte = eeIf.rdData;
         end
         default: rdByte = 8'h00;
      endcase
   end
   // drive bus only while output enable low
   always_ff @(posedge clk) begin
      if (rst) begin
         dataOut <= 8'h00;
         dataOe <= 1'b0;
      end else begin
         dataOut <= rdByte;
         dataOe <= mode_q & ~oeS;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         prog_ready_flag <= 1'b1;
      end else begin
         prog_ready_flag <= (state_q == PPP_IDLE) && !doWr;
      end
   end
   logic unusedOk;
   assign unusedOk = flashAddrOk;
endmodule // ppp_port
`default_nettype wire

// [verif/ppp_port_monitor.sv]
// assertion checker for the parallel programming port pins
`default_nettype none
module ppp_port_monitor
   import ppp_pkg::*;
#(
   parameter logic [7:0] CAL8 = CAL8_DEF,
   parameter int BUSY_CYC = BUSY_CYC_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // programmer pins
   input wire logic hvReset,
   input wire logic writeStrobeN,
   input wire logic outEnableN,
   input wire logic dataOe,
   input wire logic prog_ready_flag,
   // device status
   input wire logic progMode,
   input wire logic [7:0] fuseLoActive,
   input wire logic [7:0] fuseHiActive,
   input wire logic [7:0] fuseExtActive,
   input wire logic keep_eeprom_on_erase,
   input wire logic [7:0] oscillator_trim_register
);
   // ----
   // checks
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // busy must last a few cycles, then end within the erase bound
   sequence busyRun;
      !prog_ready_flag [*3];
   endsequence
   // longest busy: full erase sweep, then page walk or settle time
   localparam int BUSY_MAX = 1024 + BUSY_CYC + 32;
   logic [15:0] busyLen_q;
   // busy length counter, too long for a delay range
   always_ff @(posedge clk) begin
      if (rst || prog_ready_flag) begin
         busyLen_q <= 16'h0000;
      end else begin
         busyLen_q <= busyLen_q + 16'h0001;
      end
   end
   a_trim_after_reset: assert property ($fell(rst) |-> oscillator_trim_register == CAL8)
      else $error("trim differs from calibration after reset");
   a_oe_released: assert property (outEnableN [*6] |-> !dataOe)
      else $error("data bus driven with output enable high");
   a_oe_mode: assert property ((!progMode) [*3] |-> !dataOe)
      else $error("data bus driven outside programming mode");
   a_mode_exit: assert property ((!hvReset) [*6] |-> !progMode)
      else $error("programming mode kept without high voltage");
   a_fuse_held: assert property (progMode [*6] |->
      $stable(fuseLoActive) && $stable(fuseHiActive) && $stable(fuseExtActive))
      else $error("active fuses changed inside programming mode");
   a_keep_tracks: assert property ((!progMode) [*4] |->
      keep_eeprom_on_erase == !fuseHiActive[KEEP_EE_BIT])
      else $error("keep eeprom flag disagrees with high fuse");
   a_busy_window: assert property ($fell(prog_ready_flag) |-> busyRun)
      else $error("busy period too short");
   a_busy_bounded: assert property (int'(busyLen_q) <= BUSY_MAX)
      else $error("busy period never ended");
   a_ready_idle: assert property (writeStrobeN [*8] ##0 prog_ready_flag |=> prog_ready_flag)
      else $error("ready dropped without a write strobe");
endmodule // ppp_port_monitor

bind ppp_port ppp_port_monitor #(.CAL8(CAL8), .BUSY_CYC(BUSY_CYC)) ppp_port_monitor_inst (
   .clk(clk), .rst(rst), .hvReset(hvReset), .writeStrobeN(writeStrobeN),
   .outEnableN(outEnableN), .dataOe(dataOe), .prog_ready_flag(prog_ready_flag),
   .progMode(progMode), .fuseLoActive(fuseLoActive), .fuseHiActive(fuseHiActive),
   .fuseExtActive(fuseExtActive), .keep_eeprom_on_erase(keep_eeprom_on_erase),
   .oscillator_trim_register(oscillator_trim_register)
);
`default_nettype wire

// [verif/ppp_programmer.sv]
// behavioural model of the external parallel programmer
`default_nettype none
module ppp_programmer
   import ppp_pkg::*;
(
   // clock and answers
   input wire logic clk,
   input wire logic [7:0] dataOut,
   input wire logic dataOe,
   input wire logic prog_ready_flag,
   // pins toward the port
   output logic hvReset,
   output logic load_strobe,
   output logic action_code_bit0,
   output logic action_code_bit1,
   output logic byte_select_lo,
   output logic writeStrobeN,
   output logic outEnableN,
   output logic [7:0] dataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] busDrv;
   // shared data line, the port wins while it drives
   assign dataIn = dataOe ? dataOut : busDrv;
   initial begin
      hvReset = 1'b0;
      load_strobe = 1'b0;
      {action_code_bit1, action_code_bit0} = 2'h0;
      byte_select_lo = 1'b0;
      writeStrobeN = 1'b0;
      outEnableN = 1'b1;
      busDrv = 8'h00;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // hold pattern, then wait before commands
   task automatic enter();
      hold(4);
      hvReset <= 1'b1;
      hold(ENTRY_HOLD_CYC);
      writeStrobeN <= 1'b1;
      hold(CMD_WAIT_CYC - ENTRY_HOLD_CYC);
   endtask
   task automatic leave();
      hvReset <= 1'b0;
      hold(8);
   endtask
   // strobe kept for the minimum width
   task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
      {action_code_bit1, action_code_bit0} <= act;
      byte_select_lo <= bs;
      busDrv <= d;
      hold(2);
      load_strobe <= 1'b1;
      hold(PULSE_MIN_CYC);
      load_strobe <= 1'b0;
      hold(PULSE_MIN_CYC);
   endtask
   // release the line (inverted, so stale data cannot pass) and read
   task automatic read(input logic bs, input logic bs2, output logic [7:0] d);
      byte_select_lo <= bs;
      action_code_bit1 <= bs2;
      outEnableN <= 1'b0;
      busDrv <= ~busDrv;
      hold(PULSE_MIN_CYC);
      d = dataIn;
      outEnableN <= 1'b1;
      hold(4);
   endtask
   // write pulse, then no new command until ready
   task automatic strobeWrite(input logic bs, input logic bs2, output logic sawBusy,
      output logic sawReady);
      sawBusy = 1'b0;
      sawReady = 1'b0;
      byte_select_lo <= bs;
      action_code_bit1 <= bs2;
      hold(2);
      writeStrobeN <= 1'b0;
      for (int n = 0; n < 2000 && !sawReady; n++) begin
         @(posedge clk);
         if (n == PULSE_MIN_CYC) writeStrobeN <= 1'b1;
         if (!prog_ready_flag) sawBusy = 1'b1;
         else if (sawBusy && n > PULSE_MIN_CYC) sawReady = 1'b1;
      end
      hold(2);
   endtask
endmodule // ppp_programmer
`default_nettype wire

// [verif/ppp_port_tb.sv]
// self-checking testbench for the parallel programming port
`default_nettype none
module ppp_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ppp_pkg::*;
   logic clk, rst, hvReset, load_strobe, action_code_bit0, action_code_bit1, byte_select_lo;
   logic writeStrobeN, outEnableN, dataOe, prog_ready_flag, progMode, keep_eeprom_on_erase;
   logic [7:0] dataIn, dataOut, fuseLoActive, fuseHiActive, fuseExtActive;
   logic [7:0] oscillator_trim_register, lockBits, rdByte;
   logic sawBusy, sawReady;
   int num_errors = 0;
   int check_count = 0;
   // short busy time keeps the run brief
   ppp_port #(.BUSY_CYC(4)) ppp_port_inst (.clk(clk), .rst(rst), .hvReset(hvReset),
      .load_strobe(load_strobe), .action_code_bit0(action_code_bit0),
      .action_code_bit1(action_code_bit1), .byte_select_lo(byte_select_lo),
      .writeStrobeN(writeStrobeN), .outEnableN(outEnableN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .prog_ready_flag(prog_ready_flag),
      .progMode(progMode), .fuseLoActive(fuseLoActive), .fuseHiActive(fuseHiActive),
      .fuseExtActive(fuseExtActive), .keep_eeprom_on_erase(keep_eeprom_on_erase),
      .oscillator_trim_register(oscillator_trim_register), .lockBits(lockBits));
   ppp_programmer ppp_programmer_inst (.clk(clk), .dataOut(dataOut), .dataOe(dataOe),
      .prog_ready_flag(prog_ready_flag), .hvReset(hvReset), .load_strobe(load_strobe),
      .action_code_bit0(action_code_bit0), .action_code_bit1(action_code_bit1),
      .byte_select_lo(byte_select_lo), .writeStrobeN(writeStrobeN),
      .outEnableN(outEnableN), .dataIn(dataIn));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ld(input logic [1:0] act, input logic bs, input logic [7:0] d);
      ppp_programmer_inst.load(act, bs, d);
   endtask
   // command and address are reloaded, then one byte is read
   task automatic peek(input logic [7:0] cmd, input logic [7:0] lo, input logic bs,
      input logic bs2);
      ld(ACT_CMD, 1'b0, cmd);
      ld(ACT_ADDR, 1'b1, 8'h00);
      ld(ACT_ADDR, 1'b0, lo);
      ppp_programmer_inst.read(bs, bs2, rdByte);
   endtask
   task automatic put(input logic [7:0] cmd, input logic [7:0] d, input logic bs);
      ld(ACT_CMD, 1'b0, cmd);
      ld(ACT_DATA, 1'b0, d);
      ppp_programmer_inst.strobeWrite(bs, 1'b0, sawBusy, sawReady);
      check({sawBusy, sawReady}, 2'h3);
   endtask
   task automatic t_reset();
      check(oscillator_trim_register, CAL8_DEF);
      check({fuseLoActive, fuseHiActive}, {FUSE_LO_RST, FUSE_HI_RST});
      check({fuseExtActive, lockBits}, {FUSE_EXT_RST, LOCK_RST});
      check({progMode, prog_ready_flag, dataOe}, 3'h2);
   endtask
   task automatic t_signature();
      logic [7:0] sig [3] = '{SIG0_DEF, SIG1_DEF, SIG2_DEF};
      ppp_programmer_inst.enter();
      check(progMode, 1'b1);
      ld(ACT_CMD, 1'b0, CMD_RD_SIG);
      // idle action must leave the command in place
      ld(ACT_IDLE, 1'b0, CMD_RD_FLASH);
      for (int i = 0; i < 3; i++) begin
         ld(ACT_ADDR, 1'b0, 8'(i));
         ppp_programmer_inst.read(1'b0, 1'b0, rdByte);
         check(rdByte, sig[i]);
         ppp_programmer_inst.read(1'b1, 1'b0, rdByte);
         if (i < 2) check(rdByte, (i == 1) ? CAL4_DEF : CAL8_DEF);
      end
   endtask
   task automatic t_memories();
      put(CMD_CHIP_ERASE, 8'h00, 1'b0);
      ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
      ld(ACT_ADDR, 1'b0, 8'h23);
      ld(ACT_DATA, 1'b0, 8'ha5);
      ld(ACT_DATA, 1'b1, 8'h5c);
      ld(ACT_ADDR, 1'b1, 8'h00);
      ppp_programmer_inst.strobeWrite(1'b0, 1'b0, sawBusy, sawReady);
      check({sawBusy, sawReady}, 2'h3);
      peek(CMD_RD_FLASH, 8'h23, 1'b0, 1'b0);
      check(rdByte, 8'ha5);
      ppp_programmer_inst.read(1'b1, 1'b0, rdByte);
      check(rdByte, 8'h5c);
      peek(CMD_RD_FLASH, 8'h13, 1'b0, 1'b0);
      check(rdByte, ERASED_BYTE);
      ld(ACT_CMD, 1'b0, CMD_WR_EE);
      ld(ACT_ADDR, 1'b1, 8'h00);
      ld(ACT_ADDR, 1'b0, 8'h45);
      put(CMD_WR_EE, 8'h3e, 1'b0);
      peek(CMD_RD_EE, 8'h45, 1'b0, 1'b0);
      check(rdByte, 8'h3e);
      peek(CMD_RD_EE, 8'h41, 1'b0, 1'b0);
      check(rdByte, ERASED_BYTE);
   endtask
   task automatic t_fuse_erase_lock();
      put(CMD_WR_FUSE, 8'h9f, 1'b1);
      check(keep_eeprom_on_erase, 1'b1);
      check(fuseHiActive, FUSE_HI_RST);
      peek(CMD_RD_FUSE, 8'h00, 1'b1, 1'b1);
      check(rdByte, 8'h9f);
      put(CMD_CHIP_ERASE, 8'h00, 1'b0);
      peek(CMD_RD_FLASH, 8'h23, 1'b0, 1'b0);
      check(rdByte, ERASED_BYTE);
      peek(CMD_RD_EE, 8'h45, 1'b0, 1'b0);
      check(rdByte, 8'h3e);
      put(CMD_WR_LOCK, 8'hfc, 1'b0);
      check(lockBits, 8'hfc);
      peek(CMD_RD_SIG, 8'h02, 1'b0, 1'b0);
      check(rdByte, SIG2_DEF);
      peek(CMD_RD_FLASH, 8'h13, 1'b0, 1'b0);
      check(rdByte, 8'h00);
   endtask
   task automatic t_exit();
      ppp_programmer_inst.leave();
      check(progMode, 1'b0);
      check(fuseHiActive, 8'h9f);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      check(oscillator_trim_register, CAL8_DEF);
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      t_reset();
      t_signature();
      t_memories();
      t_fuse_erase_lock();
      t_exit();
      end_of_test();
   end
endmodule // ppp_port_tb
`default_nettype wire
